// ===== hw/pfs_defs.vh
// Constants for the display power flags and power-up sequencer block.
// Assumes a 100 MHz system clock and a same-clock register access port.
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define PFS_ADDR_EN1        8'h05
`define PFS_ADDR_EN2        8'h06
`define PFS_ADDR_FLAGS1     8'h07
`define PFS_ADDR_FLAGS2     8'h08
`define PFS_ADDR_ORDER      8'h09
`define PFS_ADDR_DELAYS     8'h0A

// ****************************************
// Reset values
// ****************************************
`define PFS_RST_EN1         8'h7F
`define PFS_RST_EN2         8'hFF
`define PFS_RST_FLAGS       8'h00
`define PFS_RST_ORDER       8'hE4
`define PFS_RST_DELAYS      8'h55
`define PFS_RDATA_NONE      8'h00

// ****************************************
// First enable register fixed bits
// ****************************************
`define PFS_EN1_WR_MASK     8'h7C
`define PFS_EN1_RO_ONES     8'h03

// ****************************************
// First flag register bit positions
// ****************************************
`define PFS_F1_TEMP_CHANGE  7
`define PFS_F1_SHUTDOWN     6
`define PFS_F1_EARLY_WARN   5
`define PFS_F1_WARM         4
`define PFS_F1_CHILL        3
`define PFS_F1_IN_UV        2
`define PFS_F1_MEAS_DONE    1
`define PFS_F1_PROG_DONE    0

// ****************************************
// Second flag register bit positions
// ****************************************
`define PFS_F2_BOOST_UV     7
`define PFS_F2_GPOS_UV      6
`define PFS_F2_INV_UV       5
`define PFS_F2_SPOS_UV      4
`define PFS_F2_GNEG_UV      3
`define PFS_F2_BIAS_FAULT   2
`define PFS_F2_SNEG_UV      1
`define PFS_F2_CONV_DONE    0

// ****************************************
// Rail indices (order field index too)
// ****************************************
`define PFS_RAIL_SNEG       0
`define PFS_RAIL_GNEG       1
`define PFS_RAIL_SPOS       2
`define PFS_RAIL_GPOS       3
`define PFS_LAST_STEP       2'h3

// ****************************************
// Timing
// ****************************************
`define PFS_CLK_KHZ         100000
`define PFS_STEP_MS         4'h3
`define PFS_TEMP_DELTA      8'h03

// ****************************************
// Synchronised input vector layout
// ****************************************
`define PFS_NSYNC           17
`define PFS_S_SHUTDOWN      0
`define PFS_S_EARLY_WARN    1
`define PFS_S_WARM          2
`define PFS_S_CHILL         3
`define PFS_S_IN_UV         4
`define PFS_S_BOOST_UV      5
`define PFS_S_GPOS_UV       6
`define PFS_S_INV_UV        7
`define PFS_S_SPOS_UV       8
`define PFS_S_GNEG_UV       9
`define PFS_S_BIAS_FAULT    10
`define PFS_S_SNEG_UV       11
`define PFS_S_MEAS_DONE     12
`define PFS_S_PROG_DONE     13
`define PFS_S_CONV_DONE     14
`define PFS_S_WAKE          15
`define PFS_S_INV_PG        16

`endif

// ===== hw/pfs_sync.v
// Two-stage synchroniser for a vector of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherence.
module pfs_sync
#(
  parameter WIDTH = 1
)
(
  input  wire             i_sys_clk,
  input  wire             i_reset_n,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  // ****************************************
  // Per-bit flop pairs
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg meta_q;   // First stage, read only by second
      reg sync_q;   // Second stage, safe to use

      // Catch then settle
      always @(posedge i_sys_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= i_async[g];
          sync_q <= meta_q;
        end
      end

      assign o_sync[g] = sync_q;
    end
  endgenerate

endmodule

// ===== hw/pfs_step_timer.v
// Millisecond delay timer for the power-up sequencer.
// Assumes a one-cycle start pulse and no restart while running.
module pfs_step_timer
#(
  parameter CYC_PER_MS = 100000
)
(
  input  wire       i_sys_clk,
  input  wire       i_reset_n,
  input  wire       i_start,
  input  wire       i_abort,
  input  wire [3:0] i_ms,
  output reg        o_done
);

  // ****************************************
  // Counters
  // ****************************************
  reg [16:0] cyc_q;   // Cycles within the current millisecond
  reg [3:0]  ms_q;    // Milliseconds still to run
  reg        run_q;   // Timer active

  // Last cycle of one millisecond
  wire ms_end = (cyc_q == CYC_PER_MS[16:0] - 17'h00001);

  // Count down; done pulses once on the final cycle
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      cyc_q  <= 17'h00000;
      ms_q   <= 4'h0;
      run_q  <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_abort)
      begin
        // Sequence dropped, stop silently
        run_q <= 1'b0;
        cyc_q <= 17'h00000;
      end
      else if (i_start)
      begin
        run_q <= 1'b1;
        cyc_q <= 17'h00000;
        ms_q  <= i_ms;
      end
      else if (run_q)
      begin
        if (ms_end)
        begin
          cyc_q <= 17'h00000;
          ms_q  <= ms_q - 4'h1;
          if (ms_q == 4'h1)
          begin
            run_q  <= 1'b0;
            o_done <= 1'b1;
          end
        end
        else
        begin
          cyc_q <= cyc_q + 17'h00001;
        end
      end
    end
  end

endmodule

// ===== hw/pfs_top.v
// Fault and event flags, interrupt output and power-up rail sequencer.
// Assumes an upstream serial front end on i_sys_clk that issues one-cycle
// register read and write strobes; analog comparators arrive as raw pins.
`include "pfs_defs.vh"

// What this block does
// - Conversion-done enable, enable2 bit0, resets on
// - Enabled set flag pulls irq low
// - Temperature change of three sets bit7
// - Bit6 shows thermal shutdown
// - Bit5 shows approaching shutdown warning
// - Bit4 set when thermistor warm
// - Bit3 set when thermistor chill
// - Bit2 set on input undervoltage
// - Bits1,0 bias measure, program done
// - Flags2 bit7 boost rail undervoltage
// - Bits6,3 gate charge-pump undervoltages
// - Bit5 inverting converter undervoltage
// - Bits4,1 source regulator undervoltages
// - Bit2 bias output out of range
// - Bit0 temperature conversion complete
// - Order register resets to E4h
// - Initial delay after power-good before strobe one
// - Delay codes select 3,6,9,12 ms
// - Delay register resets to 55h
// - Each flags2 bit has enable, resets on
module pfs_top
#(
  parameter CYC_PER_MS = `PFS_CLK_KHZ
)
(
  input  wire       i_sys_clk,
  input  wire       i_reset_n,
  input  wire [7:0] i_reg_addr,
  input  wire       i_reg_wr_en,
  input  wire       i_reg_rd_en,
  input  wire [7:0] i_reg_wdata,
  output reg  [7:0] o_reg_rdata,
  input  wire       i_thermal_shutdown,
  input  wire       i_thermal_warning,
  input  wire       i_thermistor_warm,
  input  wire       i_thermistor_chill,
  input  wire       i_input_undervolt,
  input  wire       i_boost_undervolt,
  input  wire       i_gate_pos_undervolt,
  input  wire       i_inverter_undervolt,
  input  wire       i_source_pos_undervolt,
  input  wire       i_gate_neg_undervolt,
  input  wire       i_bias_out_of_range,
  input  wire       i_source_neg_undervolt,
  input  wire       i_bias_measure_done,
  input  wire       i_bias_program_done,
  input  wire       i_conv_done,
  input  wire       i_power_up_req,
  input  wire       i_inverter_power_good,
  input  wire [7:0] i_temp_value,
  input  wire       i_temp_valid,
  output reg        o_irq_out_n,
  output reg  [3:0] o_rail_en,
  output reg  [3:0] o_strobe,
  output reg        o_seq_done
);

  // ****************************************
  // Sequencer states
  // ****************************************
  localparam ST_IDLE  = 2'b00;   // Rails off, waiting for request
  localparam ST_WAIT  = 2'b01;   // Waiting for inverter power good
  localparam ST_DELAY = 2'b10;   // Timing toward next strobe
  localparam ST_UP    = 2'b11;   // All four strobes issued

  // ****************************************
  // Field helper
  // ****************************************
  // Pick 2-bit field idx from a byte; used for order and delays
  function [1:0] field2;
    input [7:0] val;
    input [1:0] idx;
    begin
      field2 = val[{idx, 1'b0} +: 2];
    end
  endfunction

  // Delay code to milliseconds: 3, 6, 9 or 12
  function [3:0] step_ms;
    input [1:0] code;
    begin
      step_ms = ({2'b00, code} + 4'h1) * `PFS_STEP_MS;
    end
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  reg [7:0] en1_q;         // First flag enables
  reg [7:0] en2_q;         // Second flag enables
  reg [7:0] flags1_q;      // Thermal and bias flags
  reg [7:0] flags2_q;      // Rail fault flags
  reg [7:0] order_q;       // Rail to strobe mapping
  reg [7:0] delays_q;      // Per-step delay codes
  reg [7:0] temp_prev_q;   // Last temperature reading
  reg       temp_have_q;   // A baseline reading exists
  reg [2:0] ev_prev_q;     // Delayed event levels for edges
  reg [1:0] state_q;       // Sequencer state
  reg [1:0] step_q;        // Strobe number being timed
  reg       tmr_start_q;   // Timer kick
  reg [3:0] tmr_ms_q;      // Timer length

  wire [`PFS_NSYNC-1:0] pins;   // Synchronised pin levels
  wire                  tmr_done;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  pfs_sync
  #(
    .WIDTH (`PFS_NSYNC)
  )
  u_sync
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_async   ({i_inverter_power_good, i_power_up_req, i_conv_done,
                 i_bias_program_done, i_bias_measure_done,
                 i_source_neg_undervolt, i_bias_out_of_range,
                 i_gate_neg_undervolt, i_source_pos_undervolt,
                 i_inverter_undervolt, i_gate_pos_undervolt,
                 i_boost_undervolt, i_input_undervolt,
                 i_thermistor_chill, i_thermistor_warm,
                 i_thermal_warning, i_thermal_shutdown}),
    .o_sync    (pins)
  );

  // ****************************************
  // Event detection
  // ****************************************
  // Completion inputs are levels; flags take their rising edge
  wire [2:0] ev_now  = {pins[`PFS_S_CONV_DONE], pins[`PFS_S_PROG_DONE],
                        pins[`PFS_S_MEAS_DONE]};
  wire [2:0] ev_rise = ev_now & ~ev_prev_q;

  // Absolute change against the previous reading
  wire [7:0] temp_diff = (i_temp_value >= temp_prev_q) ?
                         (i_temp_value - temp_prev_q) :
                         (temp_prev_q - i_temp_value);
  // First reading only sets a baseline, nothing to compare yet
  wire temp_change = i_temp_valid && temp_have_q &&
                     (temp_diff >= `PFS_TEMP_DELTA);

  // Set terms per flag bit
  wire [7:0] set1;
  wire [7:0] set2;
  assign set1[`PFS_F1_TEMP_CHANGE] = temp_change;
  assign set1[`PFS_F1_SHUTDOWN]    = pins[`PFS_S_SHUTDOWN];
  assign set1[`PFS_F1_EARLY_WARN]  = pins[`PFS_S_EARLY_WARN];
  assign set1[`PFS_F1_WARM]        = pins[`PFS_S_WARM];
  assign set1[`PFS_F1_CHILL]       = pins[`PFS_S_CHILL];
  assign set1[`PFS_F1_IN_UV]       = pins[`PFS_S_IN_UV];
  assign set1[`PFS_F1_MEAS_DONE]   = ev_rise[0];
  assign set1[`PFS_F1_PROG_DONE]   = ev_rise[1];
  assign set2[`PFS_F2_BOOST_UV]    = pins[`PFS_S_BOOST_UV];
  assign set2[`PFS_F2_GPOS_UV]     = pins[`PFS_S_GPOS_UV];
  assign set2[`PFS_F2_INV_UV]      = pins[`PFS_S_INV_UV];
  assign set2[`PFS_F2_SPOS_UV]     = pins[`PFS_S_SPOS_UV];
  assign set2[`PFS_F2_GNEG_UV]     = pins[`PFS_S_GNEG_UV];
  assign set2[`PFS_F2_BIAS_FAULT]  = pins[`PFS_S_BIAS_FAULT];
  assign set2[`PFS_F2_SNEG_UV]     = pins[`PFS_S_SNEG_UV];
  assign set2[`PFS_F2_CONV_DONE]   = ev_rise[2];

  // Read strobes that clear flags
  wire rd_f1 = i_reg_rd_en && (i_reg_addr == `PFS_ADDR_FLAGS1);
  wire rd_f2 = i_reg_rd_en && (i_reg_addr == `PFS_ADDR_FLAGS2);

  // ****************************************
  // Flag registers
  // ****************************************
  // Sticky until read; a set in the read cycle wins so nothing is lost,
  // and a fault still present simply re-sets the bit
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      flags1_q    <= `PFS_RST_FLAGS;
      flags2_q    <= `PFS_RST_FLAGS;
      ev_prev_q   <= 3'h0;
      temp_prev_q <= 8'h00;
      temp_have_q <= 1'b0;
    end
    else
    begin
      flags1_q  <= set1 | (flags1_q & {8{~rd_f1}});
      flags2_q  <= set2 | (flags2_q & {8{~rd_f2}});
      ev_prev_q <= ev_now;
      // Each new reading becomes the reference for the next
      if (i_temp_valid)
      begin
        temp_prev_q <= i_temp_value;
        temp_have_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Only the listed registers take writes; flag registers ignore them
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      en1_q    <= `PFS_RST_EN1;
      en2_q    <= `PFS_RST_EN2;
      order_q  <= `PFS_RST_ORDER;
      delays_q <= `PFS_RST_DELAYS;
    end
    else if (i_reg_wr_en)
    begin
      if (i_reg_addr == `PFS_ADDR_EN1)
      begin
        // Temperature-change enable reads zero, bias enables stay on
        en1_q <= (i_reg_wdata & `PFS_EN1_WR_MASK) | `PFS_EN1_RO_ONES;
      end
      else if (i_reg_addr == `PFS_ADDR_EN2)
      begin
        en2_q <= i_reg_wdata;
      end
      else if (i_reg_addr == `PFS_ADDR_ORDER)
      begin
        order_q <= i_reg_wdata;
      end
      else if (i_reg_addr == `PFS_ADDR_DELAYS)
      begin
        delays_q <= i_reg_wdata;
      end
    end
  end

  // ****************************************
  // Register reads
  // ****************************************
  // Registered read data: valid the cycle after the read strobe
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_reg_rdata <= `PFS_RDATA_NONE;
    end
    else if (i_reg_rd_en)
    begin
      if (i_reg_addr == `PFS_ADDR_EN1)
      begin
        o_reg_rdata <= en1_q;
      end
      else if (i_reg_addr == `PFS_ADDR_EN2)
      begin
        o_reg_rdata <= en2_q;
      end
      else if (i_reg_addr == `PFS_ADDR_FLAGS1)
      begin
        o_reg_rdata <= flags1_q;
      end
      else if (i_reg_addr == `PFS_ADDR_FLAGS2)
      begin
        o_reg_rdata <= flags2_q;
      end
      else if (i_reg_addr == `PFS_ADDR_ORDER)
      begin
        o_reg_rdata <= order_q;
      end
      else if (i_reg_addr == `PFS_ADDR_DELAYS)
      begin
        o_reg_rdata <= delays_q;
      end
      else
      begin
        o_reg_rdata <= `PFS_RDATA_NONE;   // Unmapped reads as zero
      end
    end
  end

  // ****************************************
  // Interrupt output
  // ****************************************
  // Low while any enabled flag is set, high otherwise
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_irq_out_n <= 1'b1;
    end
    else
    begin
      o_irq_out_n <= ~(|(flags1_q & en1_q) |
                       |(flags2_q & en2_q));
    end
  end

  // ****************************************
  // Step timer
  // ****************************************
  pfs_step_timer
  #(
    .CYC_PER_MS (CYC_PER_MS)
  )
  u_timer
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_start   (tmr_start_q),
    .i_abort   (~pins[`PFS_S_WAKE]),
    .i_ms      (tmr_ms_q),
    .o_done    (tmr_done)
  );

  // ****************************************
  // Rail selection per strobe
  // ****************************************
  // Rails whose order code equals the strobe now being issued
  wire [3:0] rail_hit;
  genvar r;
  generate
    for (r = 0; r < 4; r = r + 1)
    begin : g_rail
      assign rail_hit[r] = (field2(order_q, r[1:0]) == step_q);
    end
  endgenerate

  // ****************************************
  // Power-up sequencer
  // ****************************************
  // Dropping the request turns all rails off at once; the ordered
  // power-down path lives elsewhere
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      state_q     <= ST_IDLE;
      step_q      <= 2'h0;
      tmr_start_q <= 1'b0;
      tmr_ms_q    <= 4'h0;
      o_rail_en   <= 4'h0;
      o_strobe    <= 4'h0;
      o_seq_done  <= 1'b0;
    end
    else
    begin
      tmr_start_q <= 1'b0;
      o_strobe    <= 4'h0;
      if (!pins[`PFS_S_WAKE])
      begin
        state_q    <= ST_IDLE;
        step_q     <= 2'h0;
        o_rail_en  <= 4'h0;
        o_seq_done <= 1'b0;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            state_q <= ST_WAIT;
          end
          ST_WAIT:
          begin
            // Initial delay starts on inverter power good
            if (pins[`PFS_S_INV_PG])
            begin
              state_q     <= ST_DELAY;
              step_q      <= 2'h0;
              tmr_start_q <= 1'b1;
              tmr_ms_q    <= step_ms(field2(delays_q, 2'h0));
            end
          end
          ST_DELAY:
          begin
            if (tmr_done)
            begin
              o_strobe[step_q] <= 1'b1;
              o_rail_en        <= o_rail_en | rail_hit;
              if (step_q == `PFS_LAST_STEP)
              begin
                state_q    <= ST_UP;
                o_seq_done <= 1'b1;
              end
              else
              begin
                step_q      <= step_q + 2'h1;
                tmr_start_q <= 1'b1;
                tmr_ms_q    <= step_ms(field2(delays_q,
                                              step_q + 2'h1));
              end
            end
          end
          default:
          begin
            state_q <= ST_UP;   // Hold rails until request drops
          end
        endcase
      end
    end
  end

endmodule

// ===== bench/pfs_top_props.sv
// Port checker for the flag and sequencer block.
// Assumes the top's two-flop pin synchroniser and its CYC_PER_MS.
module pfs_top_props
#(
  parameter int CYC_PER_MS = 100000
)
(
  input wire       i_sys_clk,
  input wire       i_reset_n,
  input wire       i_power_up_req,
  input wire       i_bias_program_done,
  input wire       i_bias_measure_done,
  input wire       o_irq_out_n,
  input wire [3:0] o_rail_en,
  input wire [3:0] o_strobe,
  input wire       o_seq_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slack of one cycle below and two above for the registered strobe path
  localparam int GAP_MIN = 3 * CYC_PER_MS - 1;
  localparam int GAP_MAX = 12 * CYC_PER_MS + 2;
  reg [20:0] gap_q; // Cycles since last strobe, holds 12 ms at 100 MHz
  reg [1:0]  nxt_q; // Strobe due next
  // A counter bounds long gaps without long repetitions
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      gap_q <= 21'h000000;
      nxt_q <= 2'h0;
    end
    else
    begin
      if (o_strobe != 4'h0)
        gap_q <= 21'h000000;
      else if (gap_q != 21'h1FFFFF)
        gap_q <= gap_q + 21'h000001;
      if (!i_power_up_req)
        nxt_q <= 2'h0;
      else if (o_strobe != 4'h0)
        nxt_q <= nxt_q + 2'h1;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Interrupt pulled low soon after a completion event
  sequence irq_soon;
    ##[1:6] !o_irq_out_n;
  endsequence
  strobe_order_a: assert property (o_strobe != 4'h0 |->
    o_strobe == (4'h1 << nxt_q)) else $error("strobe out of order");
  strobe_pulse_a: assert property (o_strobe != 4'h0 |=>
    o_strobe == 4'h0) else $error("strobe longer than a cycle");
  step_gap_a: assert property (o_strobe[3:1] != 3'h0 |->
    gap_q >= GAP_MIN && gap_q <= GAP_MAX) else $error("bad step gap");
  all_rails_a: assert property (o_strobe[3] |=>
    o_rail_en == 4'hF) else $error("rails missing after last strobe");
  done_last_a: assert property ($rose(o_seq_done) |->
    o_strobe[3]) else $error("done without last strobe");
  req_off_a: assert property ((!i_power_up_req) [*6] |->
    o_rail_en == 4'h0 && !o_seq_done) else $error("rails kept on");
  rail_grow_a: assert property ($changed(o_rail_en) &&
    o_rail_en != 4'h0 |-> o_strobe != 4'h0 || $past(o_strobe) != 4'h0)
    else $error("rail change without strobe");
  prog_irq_a: assert property ($rose(i_bias_program_done) |->
    irq_soon) else $error("no irq on program done");
  meas_irq_a: assert property ($rose(i_bias_measure_done) |->
    irq_soon) else $error("no irq on measure done");
endmodule

bind pfs_top pfs_top_props #(.CYC_PER_MS(CYC_PER_MS)) u_pfs_top_props
(
  .i_sys_clk           (i_sys_clk),
  .i_reset_n           (i_reset_n),
  .i_power_up_req      (i_power_up_req),
  .i_bias_program_done (i_bias_program_done),
  .i_bias_measure_done (i_bias_measure_done),
  .o_irq_out_n         (o_irq_out_n),
  .o_rail_en           (o_rail_en),
  .o_strobe            (o_strobe),
  .o_seq_done          (o_seq_done)
);

// ===== bench/pfs_host_model.sv
// Host side of the register strobe port.
// Assumes the bench calls wr and rd; lines move on falling edges.
module pfs_host_model
(
  input  wire logic       i_sys_clk,
  input  wire logic [7:0] i_reg_rdata,
  output logic      [7:0] o_reg_addr,
  output logic            o_reg_wr_en,
  output logic            o_reg_rd_en,
  output logic      [7:0] o_reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle port at time zero
  initial
  begin
    o_reg_addr  = 8'h00;
    o_reg_wr_en = 1'b0;
    o_reg_rd_en = 1'b0;
    o_reg_wdata = 8'h00;
  end
  // Released lines show inverted values, never stale ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg_addr  = a;
    o_reg_wdata = d;
    o_reg_wr_en = 1'b1;
    @(negedge i_sys_clk);
    o_reg_wr_en = 1'b0;
    o_reg_addr  = ~a;
    o_reg_wdata = ~d;
  endtask
  // Data taken once the registered answer has landed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_sys_clk);
    o_reg_addr  = a;
    o_reg_rd_en = 1'b1;
    @(negedge i_sys_clk);
    o_reg_rd_en = 1'b0;
    o_reg_addr  = ~a;
    @(negedge i_sys_clk);
    d = i_reg_rdata;
  endtask
endmodule

// ===== bench/pfs_top_tb.sv
// Bench for the flag and sequencer block, 100 MHz clock.
// Assumes CYC_PER_MS of 10 so each 3 ms delay unit is 30 cycles.
module pfs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, req, pg, tvalid, wr_en, rd_en, irq_n, done;
  logic [14:0] p; // Pin levels, flags2 bits then flags1 bits
  logic [7:0]  tval, addr, wdata, rdata, d, e, er;
  logic [3:0]  rails, strb;
  int num_errors = 0;
  int compares = 0;
  int i, k, n, r;
  logic [7:0] ra [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h3F};
  logic [7:0] rv [7] = '{8'h7F, 8'hFF, 8'h00, 8'h00, 8'hE4, 8'h55, 8'h00};
  pfs_host_model u_pfs_host_model
  (
    .i_sys_clk   (clk),
    .i_reg_rdata (rdata),
    .o_reg_addr  (addr),
    .o_reg_wr_en (wr_en),
    .o_reg_rd_en (rd_en),
    .o_reg_wdata (wdata)
  );
  pfs_top #(.CYC_PER_MS(10)) u_pfs_top
  (
    .i_sys_clk              (clk),
    .i_reset_n              (rst_n),
    .i_reg_addr             (addr),
    .i_reg_wr_en            (wr_en),
    .i_reg_rd_en            (rd_en),
    .i_reg_wdata            (wdata),
    .o_reg_rdata            (rdata),
    .i_thermal_shutdown     (p[14]),
    .i_thermal_warning      (p[13]),
    .i_thermistor_warm      (p[12]),
    .i_thermistor_chill     (p[11]),
    .i_input_undervolt      (p[10]),
    .i_boost_undervolt      (p[7]),
    .i_gate_pos_undervolt   (p[6]),
    .i_inverter_undervolt   (p[5]),
    .i_source_pos_undervolt (p[4]),
    .i_gate_neg_undervolt   (p[3]),
    .i_bias_out_of_range    (p[2]),
    .i_source_neg_undervolt (p[1]),
    .i_bias_measure_done    (p[9]),
    .i_bias_program_done    (p[8]),
    .i_conv_done            (p[0]),
    .i_power_up_req         (req),
    .i_inverter_power_good  (pg),
    .i_temp_value           (tval),
    .i_temp_valid           (tvalid),
    .o_irq_out_n            (irq_n),
    .o_rail_en              (rails),
    .o_strobe               (strb),
    .o_seq_done             (done)
  );
  // ****************************************
  // Clock, checks and verdict
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One temperature reading, one-cycle valid
  task automatic temp(input logic [7:0] v);
    @(negedge clk);
    tval = v;
    tvalid = 1'b1;
    @(negedge clk);
    tvalid = 1'b0;
  endtask
  // Whole run is about 700 cycles; this cuts a hang
  initial
  begin
    #100000;
    num_errors++;
    final_report();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    p = 15'h0000;
    req = 1'b0;
    pg = 1'b0;
    tval = 8'h00;
    tvalid = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    // Reset values, last address unmapped
    for (i = 0; i < 7; i++)
    begin
      u_pfs_host_model.rd(ra[i], d);
      check(d, rv[i]);
    end
    u_pfs_host_model.wr(8'h09, 8'h1B);
    u_pfs_host_model.wr(8'h0A, 8'hE4);
    u_pfs_host_model.wr(8'h07, 8'hFF);
    u_pfs_host_model.rd(8'h09, d);
    check(d, 8'h1B);
    u_pfs_host_model.rd(8'h0A, d);
    check(d, 8'hE4);
    u_pfs_host_model.rd(8'h07, d);
    check(d, 8'h00);
    // First enables: bit7 stuck low, bits1,0 stuck high
    u_pfs_host_model.wr(8'h05, 8'h00);
    u_pfs_host_model.rd(8'h05, d);
    check(d, 8'h03);
    // Disabled shutdown flag is recorded but leaves the irq high
    p[14] = 1'b1;
    repeat (6) @(negedge clk);
    check({7'h00, irq_n}, 8'h01);
    p[14] = 1'b0;
    repeat (4) @(negedge clk);
    u_pfs_host_model.rd(8'h07, d);
    check(d, 8'h40);
    u_pfs_host_model.wr(8'h05, 8'hFF);
    u_pfs_host_model.rd(8'h05, d);
    check(d, 8'h7F);
    // Each pin sets its own bit, sticks, clears on read
    for (i = 0; i < 15; i++)
    begin
      p[i] = 1'b1;
      repeat (5) @(negedge clk);
      check({7'h00, irq_n}, 8'h00);
      p[i] = 1'b0;
      repeat (5) @(negedge clk);
      addr_sel(i);
      u_pfs_host_model.rd(e, d);
      check(d, er);
      u_pfs_host_model.rd(e, d);
      check(d, 8'h00);
      check({7'h00, irq_n}, 8'h01);
    end
    // Disabled conversion-done flag leaves the irq high
    u_pfs_host_model.wr(8'h06, 8'hFE);
    p[0] = 1'b1;
    repeat (6) @(negedge clk);
    check({7'h00, irq_n}, 8'h01);
    u_pfs_host_model.rd(8'h08, d);
    check(d, 8'h01);
    p[0] = 1'b0;
    u_pfs_host_model.wr(8'h06, 8'hFF);
    // Change of two is quiet, change of three flags
    temp(8'd100);
    temp(8'd102);
    u_pfs_host_model.rd(8'h07, d);
    check(d, 8'h00);
    temp(8'd105);
    repeat (3) @(negedge clk);
    check({7'h00, irq_n}, 8'h01);
    u_pfs_host_model.rd(8'h07, d);
    check(d, 8'h80);
    // Reversed order, steps of 3, 6, 9 and 12 ms
    req = 1'b1;
    // No rail or done until inverter power good arrives
    repeat (20) @(negedge clk);
    check({3'h0, done, rails}, 8'h00);
    pg = 1'b1;
    n = 0;
    for (k = 0; k < 4; k++)
    begin
      while (strb === 4'h0 && n < 400)
      begin
        @(negedge clk);
        n++;
      end
      check({4'h0, strb}, 8'h01 << k);
      check({7'h00, n >= 30 * (k + 1) && n <= 30 * (k + 1) + 8},
            8'h01);
      @(negedge clk);
      er = 8'h00;
      for (r = 0; r < 4; r++)
        if (((8'h1B >> (2 * r)) & 8'h03) <= k)
          er[r] = 1'b1;
      check({4'h0, rails}, er);
      n = 1;
    end
    check({7'h00, done}, 8'h01);
    req = 1'b0;
    repeat (6) @(negedge clk);
    check({3'h0, done, rails}, 8'h00);
    final_report();
  end
  // Expected register and bit for pin index
  task automatic addr_sel(input int idx);
    e = (idx < 8) ? 8'h08 : 8'h07;
    er = (idx < 8) ? (8'h01 << idx) : (8'h01 << (idx - 8));
  endtask
endmodule
